/* design/supervisor_device.sv */
`timescale 1ns/1ps
// Behaviour
// - Alert pulled low on any pending event
// - Reset low while supply below threshold
// - Reset held 200 ms after supply returns
// - External reset over 1 us restarts hold
// - Mid-level kick disables watchdog, output high
// - Kick unchanged past timeout drives output low
// - Kick transition restores output, restarts timing
// - Data driven only during requested read
// - Write strobe captures data into register
// - Host keeps strobe high while address moves
// - Data pins released while read inactive
// - Sixteen byte registers, 4-bit index
// - Write spans overlap of select and strobe
// - Data held at first rising edge
module supervisor_device #(
  // Timebase and supervisor counts
  parameter int DIV_CYCLES = supervisor_pkg::TICK_DIV,
  parameter int HOLD_LEN   = supervisor_pkg::HOLD_TICKS,
  parameter int WDOG_LEN   = supervisor_pkg::WDOG_TICKS
) (
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            nrst,
  input  wire logic            clk_en,
  // Analogue and event inputs
  input  wire logic            supply_low,
  input  wire logic            periodic_event,
  input  wire logic            alarm_event,
  // Link
  supervisor_if.device         bus
);
  import supervisor_pkg::*;

  // ---------------------------------------------------------------
  // Synchronisers
  // ---------------------------------------------------------------
  logic [7:0]  s1_r, s2_r, s1_nxt, s2_nxt;
  logic        cs_s, rd_s, wr_s, rstl_s, sup_s;
  kick_level_t kick_s;
  logic [DATA_W+INDEX_W-1:0] d1_r, d2_r, d1_nxt, d2_nxt;
  logic [DATA_W-1:0]         data_s;
  logic [INDEX_W-1:0]        idx_s;

  always_comb
  begin
    s1_nxt = {bus.cs_n, bus.rd_n, bus.wr_n, bus.rst_line_n, supply_low,
              1'b0, bus.kick_input};
    s2_nxt = s1_r;
    // Data and index ride the same two stages as the strobes, so the last sample in a write still belongs to it.
    d1_nxt = {bus.data_bus, bus.register_index};
    d2_nxt = d1_r;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_r <= 8'hf2;
      s2_r <= 8'hf2;
      d1_r <= '0;
      d2_r <= '0;
    end
    else if (clk_en)
    begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      d1_r <= d1_nxt;
      d2_r <= d2_nxt;
    end
  end

  assign cs_s   = s2_r[7];
  assign rd_s   = s2_r[6];
  assign wr_s   = s2_r[5];
  assign rstl_s = s2_r[4];
  assign sup_s  = s2_r[3];
  assign kick_s = kick_level_t'(s2_r[1:0]);
  assign data_s = d2_r[DATA_W+INDEX_W-1:INDEX_W];
  assign idx_s  = d2_r[INDEX_W-1:0];

  // ---------------------------------------------------------------
  // Timebase
  // ---------------------------------------------------------------
  logic [15:0] div_r, div_nxt;
  logic        tick;

  assign tick = (div_r == 16'(DIV_CYCLES - 1));

  always_comb
  begin
    div_nxt = tick ? 16'h0000 : div_r + 16'h0001;
  end

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] regs_r [REG_NUM];
  logic [DATA_W-1:0] regs_nxt [REG_NUM];
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic [INDEX_W-1:0] widx_r, widx_nxt;
  logic              wact_r, wact_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic              roe_n_r, roe_n_nxt;

  always_comb
  begin
    regs_nxt  = regs_r;
    wact_nxt  = !cs_s && !wr_s;
    // Sample data while the strobes overlap; the last sample is what lands.
    wdata_nxt = wact_nxt ? data_s : wdata_r;
    widx_nxt  = wact_nxt ? idx_s : widx_r;
    if (wact_r && !wact_nxt)
      regs_nxt[widx_r] = wdata_r;
    roe_n_nxt = !(!cs_s && !rd_s && wr_s);
    rdata_nxt = regs_r[idx_s];
  end

  assign bus.dev_data_o    = rdata_r;
  assign bus.dev_data_oe_n = roe_n_r;

  // ---------------------------------------------------------------
  // Reset supervisor
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {RS_FAIL, RS_HOLD, RS_RUN} rst_state_t;
  rst_state_t  rs_r, rs_nxt;
  logic [15:0] hold_r, hold_nxt;
  logic [7:0]  push_r, push_nxt;
  logic        drive_r, drive_nxt;

  always_comb
  begin
    rs_nxt   = rs_r;
    hold_nxt = hold_r;
    // External low counted only while we are not driving the line ourselves.
    push_nxt = (!rstl_s && !drive_r) ?
               ((push_r == 8'hff) ? push_r : push_r + 8'h01) : 8'h00;
    if (sup_s)
      rs_nxt = RS_FAIL;
    else
      unique case (rs_r)
        RS_FAIL:
        begin
          rs_nxt   = RS_HOLD;
          hold_nxt = 16'h0000;
        end
        RS_HOLD:
        begin
          if (tick)
            hold_nxt = hold_r + 16'h0001;
          if (hold_r >= 16'(HOLD_LEN))
            rs_nxt = RS_RUN;
        end
        RS_RUN:
        begin
          if (rstl_s && push_r >= 8'(PUSH_CYCLES))
          begin
            rs_nxt   = RS_HOLD;
            hold_nxt = 16'h0000;
          end
        end
      endcase
    drive_nxt = (rs_nxt != RS_RUN);
  end

  assign bus.dev_rst_oe_n = !drive_r;

  // ---------------------------------------------------------------
  // Watchdog and alert
  // ---------------------------------------------------------------
  kick_level_t kprev_r, kprev_nxt;
  logic [15:0] wd_r, wd_nxt;
  logic        wdo_r, wdo_nxt;
  logic        alert_r, alert_nxt;

  always_comb
  begin
    kprev_nxt = kick_s;
    wd_nxt    = wd_r;
    wdo_nxt   = wdo_r;
    if (kick_s == KICK_MID)
    begin
      wd_nxt  = 16'h0000;
      wdo_nxt = 1'b1;
    end
    else if (kick_s != kprev_r)
    begin
      wd_nxt  = 16'h0000;
      wdo_nxt = 1'b1;
    end
    else if (tick && wdo_r)
    begin
      wd_nxt = wd_r + 16'h0001;
      if (wd_nxt >= 16'(WDOG_LEN))
        wdo_nxt = 1'b0;
    end
    alert_nxt = sup_s || periodic_event || alarm_event;
  end

  assign bus.timeout_flag_out = wdo_r;
  assign bus.alert_oe_n       = !alert_r;

  // ---------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_r   <= 16'h0000;
      for (int i = 0; i < REG_NUM; i++)
        regs_r[i] <= REG_RESET;
      wdata_r <= REG_RESET;
      widx_r  <= '0;
      wact_r  <= 1'b0;
      rdata_r <= REG_RESET;
      roe_n_r <= 1'b1;
      rs_r    <= RS_FAIL;
      hold_r  <= 16'h0000;
      push_r  <= 8'h00;
      drive_r <= 1'b1;
      kprev_r <= KICK_MID;
      wd_r    <= 16'h0000;
      wdo_r   <= 1'b1;
      alert_r <= 1'b0;
    end
    else if (clk_en)
    begin
      div_r   <= div_nxt;
      regs_r  <= regs_nxt;
      wdata_r <= wdata_nxt;
      widx_r  <= widx_nxt;
      wact_r  <= wact_nxt;
      rdata_r <= rdata_nxt;
      roe_n_r <= roe_n_nxt;
      rs_r    <= rs_nxt;
      hold_r  <= hold_nxt;
      push_r  <= push_nxt;
      drive_r <= drive_nxt;
      kprev_r <= kprev_nxt;
      wd_r    <= wd_nxt;
      wdo_r   <= wdo_nxt;
      alert_r <= alert_nxt;
    end
  end

endmodule : supervisor_device

/* inc/supervisor_pkg.sv */
package supervisor_pkg;

  // ---------------------------------------------------------------
  // Bus widths
  // ---------------------------------------------------------------
  localparam int INDEX_W  = 4;
  localparam int DATA_W   = 8;
  localparam int REG_NUM  = 16;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ          = 10_000_000;
  localparam int TICK_HZ         = 32_768;
  localparam int TICK_DIV        = CLK_HZ / TICK_HZ;
  localparam int WDOG_TIMEOUT_MS = 1500;
  localparam int WDOG_TICKS      = (WDOG_TIMEOUT_MS * TICK_HZ) / 1000;
  localparam int HOLD_MS         = 200;
  localparam int HOLD_TICKS      = (HOLD_MS * TICK_HZ) / 1000;
  localparam int PUSH_NS         = 1000;
  localparam int CLK_NS          = 100;
  localparam int PUSH_CYCLES     = (PUSH_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOST_PULSE      = 4;

  // ---------------------------------------------------------------
  // Kick input levels
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {KICK_LOW, KICK_HIGH, KICK_MID} kick_level_t;

  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

endpackage : supervisor_pkg

/* inc/supervisor_if.sv */
`timescale 1ns/1ps
interface supervisor_if;
  import supervisor_pkg::*;
  // Bus strobes and index from host, data lines from both ends.
  logic               cs_n;
  logic               rd_n;
  logic               wr_n;
  logic [INDEX_W-1:0] register_index;
  logic [DATA_W-1:0]  host_data_o;
  logic               host_data_oe_n;
  logic [DATA_W-1:0]  dev_data_o;
  logic               dev_data_oe_n;
  // Reset line, open drain from both ends.
  logic               dev_rst_oe_n;
  logic               host_rst_oe_n;
  // Alert line, open drain from device.
  logic               alert_oe_n;
  // Watchdog.
  kick_level_t        kick_input;
  logic               timeout_flag_out;

  wire [DATA_W-1:0] data_bus = !dev_data_oe_n ? dev_data_o :
                               !host_data_oe_n ? host_data_o : '0;
  wire rst_line_n  = dev_rst_oe_n & host_rst_oe_n;
  wire alert_line_n = alert_oe_n;

  modport device (
    input  cs_n, rd_n, wr_n, register_index, data_bus, rst_line_n, kick_input,
    output dev_data_o, dev_data_oe_n, dev_rst_oe_n, alert_oe_n, timeout_flag_out
  );
  modport host (
    input  data_bus, rst_line_n, alert_line_n, timeout_flag_out,
    output cs_n, rd_n, wr_n, register_index, host_data_o, host_data_oe_n,
           host_rst_oe_n, kick_input
  );
endinterface : supervisor_if

/* design/supervisor_host.sv */
`timescale 1ns/1ps
module supervisor_host (
  // Clock and reset
  input  wire logic                              core_clk,
  input  wire logic                              nrst,
  input  wire logic                              clk_en,
  // User request
  input  wire logic                              req_valid,
  input  wire logic                              req_write,
  input  wire logic [supervisor_pkg::INDEX_W-1:0] req_index,
  input  wire logic [supervisor_pkg::DATA_W-1:0]  req_wdata,
  output logic                                   req_ready,
  output logic                                   rsp_valid,
  output logic [supervisor_pkg::DATA_W-1:0]       rsp_rdata,
  // User supervisor controls
  input  wire logic                              push_reset,
  input  wire supervisor_pkg::kick_level_t        kick_level,
  output logic                                   cpu_reset_n,
  output logic                                   alert_n,
  output logic                                   timeout_n,
  // Link
  supervisor_if.host                             bus
);
  import supervisor_pkg::*;

  // ---------------------------------------------------------------
  // Bus sequencer
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_DONE} host_state_t;
  host_state_t        st_r, st_nxt;
  logic [7:0]         cnt_r, cnt_nxt;
  logic               wr_r, wr_nxt;
  logic [INDEX_W-1:0] idx_r, idx_nxt;
  logic [DATA_W-1:0]  wd_r, wd_nxt, rd_r, rd_nxt;
  logic               rv_r, rv_nxt;
  logic [2:0]         in1_r, in2_r;

  assign req_ready = (st_r == H_IDLE);

  always_comb
  begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    wr_nxt  = wr_r;
    idx_nxt = idx_r;
    wd_nxt  = wd_r;
    rd_nxt  = rd_r;
    rv_nxt  = 1'b0;
    unique case (st_r)
      H_IDLE:
        if (req_valid)
        begin
          st_nxt  = H_SETUP;
          wr_nxt  = req_write;
          idx_nxt = req_index;
          wd_nxt  = req_wdata;
          cnt_nxt = 8'h00;
        end
      H_SETUP:
      begin
        st_nxt  = H_STROBE;
        cnt_nxt = 8'h00;
      end
      H_STROBE:
      begin
        cnt_nxt = cnt_r + 8'h01;
        if (cnt_r == 8'(HOST_PULSE - 1))
        begin
          st_nxt = H_DONE;
          if (!wr_r)
          begin
            rd_nxt = bus.data_bus;
            rv_nxt = 1'b1;
          end
        end
      end
      H_DONE:
        st_nxt = H_IDLE;
    endcase
  end

  assign rsp_valid = rv_r;
  assign rsp_rdata = rd_r;

  // Select opens before the strobe and closes after it, so address is stable.
  assign bus.cs_n           = !(st_r == H_SETUP || st_r == H_STROBE || st_r == H_DONE);
  assign bus.wr_n           = !(wr_r && st_r == H_STROBE);
  assign bus.rd_n           = !(!wr_r && st_r == H_STROBE);
  assign bus.register_index = idx_r;
  assign bus.host_data_o    = wd_r;
  assign bus.host_data_oe_n = !(wr_r && st_r != H_IDLE);
  assign bus.host_rst_oe_n  = !push_reset;
  assign bus.kick_input     = kick_level;

  assign cpu_reset_n = in2_r[2];
  assign alert_n     = in2_r[1];
  assign timeout_n   = in2_r[0];

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r  <= H_IDLE;
      cnt_r <= 8'h00;
      wr_r  <= 1'b0;
      idx_r <= '0;
      wd_r  <= 8'h00;
      rd_r  <= 8'h00;
      rv_r  <= 1'b0;
      in1_r <= 3'h7;
      in2_r <= 3'h7;
    end
    else if (clk_en)
    begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      wr_r  <= wr_nxt;
      idx_r <= idx_nxt;
      wd_r  <= wd_nxt;
      rd_r  <= rd_nxt;
      rv_r  <= rv_nxt;
      in1_r <= {bus.rst_line_n, bus.alert_line_n, bus.timeout_flag_out};
      in2_r <= in1_r;
    end
  end

endmodule : supervisor_host

/* tb/supervisor_checker.sv */
`timescale 1ns/1ps
module supervisor_checker (
  // Clock and reset
  input wire logic                       core_clk,
  input wire logic                       nrst,
  // Link
  input wire logic                       cs_n,
  input wire logic                       rd_n,
  input wire logic                       wr_n,
  input wire logic [3:0]                 register_index,
  input wire logic                       host_data_oe_n,
  input wire logic                       dev_data_oe_n,
  input wire logic                       dev_rst_oe_n,
  input wire supervisor_pkg::kick_level_t kick_input,
  input wire logic                       timeout_flag_out
);
  import supervisor_pkg::*;
  // ---------------------------------------------------------------
  // Link properties
  // ---------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // A strobe pulse is four cycles low, then high again.
  sequence pulse4(s);
    !s [*4] ##1 s;
  endsequence
  strobe_excl_a: assert property (!(!rd_n && !wr_n))
    else $error("read and write strobes low together");
  write_overlap_a: assert property (!wr_n |-> !cs_n)
    else $error("write strobe low without chip select");
  wr_pulse_a: assert property ($fell(wr_n) |-> pulse4(wr_n))
    else $error("write strobe pulse has wrong width");
  rd_pulse_a: assert property ($fell(rd_n) |-> pulse4(rd_n))
    else $error("read strobe pulse has wrong width");
  addr_hold_a: assert property (!wr_n |-> $stable(register_index))
    else $error("index moved during write strobe");
  read_quiet_a: assert property (!rd_n |-> host_data_oe_n)
    else $error("host drives data during read");
  released_a: assert property (rd_n [*4] |-> dev_data_oe_n)
    else $error("device drives data with read inactive");
  drive_in_read_a: assert property ($fell(dev_data_oe_n) |-> !rd_n)
    else $error("device started driving outside a read");
  rst_hold_a: assert property ($rose(nrst) |-> !dev_rst_oe_n [*8])
    else $error("reset line released too early");
  mid_kick_a: assert property (kick_input == KICK_MID [*6] |-> timeout_flag_out)
    else $error("timeout low with watchdog disabled");
endmodule : supervisor_checker

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
  import supervisor_pkg::*;
  // Shortened counts keep the run small while exercising the same counters.
  localparam int TB_DIV  = 4;
  localparam int TB_HOLD = 40;
  localparam int TB_WDOG = 30;
  logic               core_clk;
  logic               nrst;
  logic               clk_en;
  logic               supply_low;
  logic               periodic_event;
  logic               alarm_event;
  logic               req_valid;
  logic               req_write;
  logic               push_reset;
  logic [INDEX_W-1:0] req_index;
  logic [DATA_W-1:0]  req_wdata;
  logic [DATA_W-1:0]  rsp_rdata;
  logic               req_ready;
  logic               rsp_valid;
  logic               cpu_reset_n;
  logic               alert_n;
  logic               timeout_n;
  kick_level_t        kick_level;
  int                 model [REG_NUM];
  int                 err_total;
  int                 checks_done;

  supervisor_if bus ();
  supervisor_device #(.DIV_CYCLES(TB_DIV), .HOLD_LEN(TB_HOLD), .WDOG_LEN(TB_WDOG))
    u_supervisor_device (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
    .supply_low(supply_low), .periodic_event(periodic_event), .alarm_event(alarm_event), .bus(bus));
  supervisor_host u_supervisor_host (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
    .req_valid(req_valid), .req_write(req_write), .req_index(req_index), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .push_reset(push_reset),
    .kick_level(kick_level), .cpu_reset_n(cpu_reset_n), .alert_n(alert_n), .timeout_n(timeout_n),
    .bus(bus));
  supervisor_checker u_supervisor_checker (.core_clk(core_clk), .nrst(nrst), .cs_n(bus.cs_n),
    .rd_n(bus.rd_n), .wr_n(bus.wr_n), .register_index(bus.register_index),
    .host_data_oe_n(bus.host_data_oe_n), .dev_data_oe_n(bus.dev_data_oe_n),
    .dev_rst_oe_n(bus.dev_rst_oe_n), .kick_input(bus.kick_input),
    .timeout_flag_out(bus.timeout_flag_out));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task report_and_stop();
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic pick(input int w);
    case (w)
      0: return req_ready;
      1: return rsp_valid;
      2: return alert_n;
      4: return cpu_reset_n;
      default: return timeout_n;
    endcase
  endfunction : pick

  // Bounded wait; a hang counts as a mismatch and ends the run.
  task wait_for(input int w, input logic v);
    int n;
    n = 0;
    while (pick(w) !== v)
    begin
      @(posedge core_clk);
      #1;
      n++;
      if (n > 60)
      begin
        err_total++;
        report_and_stop();
      end
    end
  endtask : wait_for

  task access(input logic wr, input int idx, input int data);
    req_valid = 1'b1;
    req_write = wr;
    req_index = idx[INDEX_W-1:0];
    req_wdata = data[DATA_W-1:0];
    wait_for(0, 1'b1);
    @(posedge core_clk);
    #1;
    req_valid = 1'b0;
    if (wr)
      model[idx] = int'(data[DATA_W-1:0]);
    else
    begin
      wait_for(1, 1'b1);
      check(rsp_rdata, model[idx][DATA_W-1:0]);
    end
    wait_for(0, 1'b1);
    repeat (4) @(posedge core_clk);
    #1;
  endtask : access

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  initial
  begin
    nrst = 1'b0;
    clk_en = 1'b1;
    {supply_low, periodic_event, alarm_event} = 3'b000;
    {req_valid, req_write, push_reset} = 3'b000;
    req_index = '0;
    req_wdata = '0;
    kick_level = KICK_MID;
    err_total = 0;
    checks_done = 0;
    void'($urandom(71));
    foreach (model[i]) model[i] = 0;
    repeat (5) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    repeat (10) @(posedge core_clk);
    #1;
    check(timeout_n, 1'b1);
    check(bus.timeout_flag_out, 1'b1);
    check(cpu_reset_n, 1'b0);
    repeat (TB_DIV * TB_HOLD - 20) @(posedge core_clk);
    #1;
    check(cpu_reset_n, 1'b0);
    wait_for(4, 1'b1);
    check(cpu_reset_n, 1'b1);
    for (int i = 0; i < REG_NUM; i++) access(1'b0, i, 0);
    for (int i = 0; i < REG_NUM; i++) access(1'b1, i, $urandom);
    access(1'b1, 5, $urandom);
    for (int i = REG_NUM - 1; i >= 0; i--) access(1'b0, i, 0);
    check(bus.dev_data_oe_n, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      {supply_low, periodic_event, alarm_event} = 3'b100 >> i;
      wait_for(2, 1'b0);
      check(bus.alert_line_n, 1'b0);
      check(cpu_reset_n, 1'b0);
      {supply_low, periodic_event, alarm_event} = 3'b000;
      wait_for(2, 1'b1);
      check(alert_n, 1'b1);
    end
    repeat (TB_DIV * TB_HOLD - 60) @(posedge core_clk);
    #1;
    check(cpu_reset_n, 1'b0);
    wait_for(4, 1'b1);
    check(cpu_reset_n, 1'b1);
    push_reset = 1'b1;
    repeat (12) @(posedge core_clk);
    #1;
    check(bus.rst_line_n, 1'b0);
    push_reset = 1'b0;
    repeat (20) @(posedge core_clk);
    #1;
    check(cpu_reset_n, 1'b0);
    repeat (TB_DIV * TB_HOLD - 60) @(posedge core_clk);
    #1;
    check(cpu_reset_n, 1'b0);
    wait_for(4, 1'b1);
    check(cpu_reset_n, 1'b1);
    // A press shorter than the minimum must not start a new hold.
    push_reset = 1'b1;
    repeat (5) @(posedge core_clk);
    #1;
    push_reset = 1'b0;
    repeat (10) @(posedge core_clk);
    #1;
    check(cpu_reset_n, 1'b1);
    // Freeze both ends mid-count; the watchdog must resume where it stopped.
    kick_level = KICK_LOW;
    repeat (10) @(posedge core_clk);
    #1;
    clk_en = 1'b0;
    repeat (TB_DIV * TB_WDOG + 80) @(posedge core_clk);
    #1;
    clk_en = 1'b1;
    repeat (10) @(posedge core_clk);
    #1;
    check(timeout_n, 1'b1);
    // Kicks well inside the shortened timeout keep the flag high.
    for (int k = 0; k < 10; k++)
    begin
      kick_level = k[0] ? KICK_HIGH : KICK_LOW;
      repeat (40) @(posedge core_clk);
      #1;
      check(timeout_n, 1'b1);
    end
    repeat (TB_DIV * TB_WDOG - 60) @(posedge core_clk);
    #1;
    check(timeout_n, 1'b1);
    wait_for(3, 1'b0);
    check(bus.timeout_flag_out, 1'b0);
    repeat (20) @(posedge core_clk);
    #1;
    check(timeout_n, 1'b0);
    kick_level = KICK_LOW;
    wait_for(3, 1'b1);
    check(bus.timeout_flag_out, 1'b1);
    repeat (TB_DIV * TB_WDOG - 50) @(posedge core_clk);
    #1;
    wait_for(3, 1'b0);
    check(timeout_n, 1'b0);
    kick_level = KICK_MID;
    wait_for(3, 1'b1);
    check(bus.timeout_flag_out, 1'b1);
    repeat (TB_DIV * TB_WDOG + 40) @(posedge core_clk);
    #1;
    check(timeout_n, 1'b1);
    report_and_stop();
  end
endmodule : tb
